// ==== common/fault_status_defines.svh ====
// constants for the communication and vendor fault status register pair
`ifndef FAULT_STATUS_DEFINES_SVH
`define FAULT_STATUS_DEFINES_SVH
`define CMD_COMM_STATUS      8'h7E
`define CMD_VENDOR_STATUS    8'h80
`define CMD_PHASE_IMBALANCE  8'hD3
`define PAGE_CH_A            8'h00
`define PAGE_CH_B            8'h01
`define PAGE_ALL             8'hFF
`define COMM_INV_CMD_BIT     7
`define COMM_INV_DATA_BIT    6
`define COMM_PEC_BIT         5
`define COMM_MEM_BIT         3
`define COMM_OTHER_BIT       1
`define COMM_IMPL_MASK       8'hEA
`define VEND_PS_BIT          7
`define VEND_SENSE_OPEN_BIT  6
`define VEND_PH_CLAMP_BIT    5
`define VEND_TSENSE_BIT      4
`define VEND_VCODE_RST_BIT   3
`define VEND_SHARE_BIT       0
`define VEND_IMPL_MASK       8'hF9
`define STATUS_RESET         8'h00
`define TSENSE_THRESH_MV     12'd150
`define SHARE_FAULT_CYCLES   3'd7
`define PHASE_MAX_A          4'd6
`define PHASE_MAX_B          4'd2
`endif

// ==== common/fault_status_if.sv ====
// link between host controller end and device status end
`timescale 1ns/1ns
interface fault_status_if;
  import fault_status_pkg::*;
  op_t   op;
  byte_t cmd;
  byte_t page;
  byte_t wdata;
  byte_t rdata;
  logic  rvalid;
  modport host (output op, output cmd, output page, output wdata, input rdata, input rvalid);
  modport dev  (input op, input cmd, input page, input wdata, output rdata, output rvalid);
endinterface

// ==== common/fault_status_pkg.sv ====
// types shared by both ends of the status register link
package fault_status_pkg;
  typedef enum logic [1:0] {
    OP_IDLE  = 2'b00,
    OP_READ  = 2'b01,
    OP_WRITE = 2'b11
  } op_t;
  typedef logic [7:0] byte_t;
endpackage

// ==== design/fault_status_dev.sv ====
// device end: latched communication and per-channel vendor fault status
// Notes on behaviour
// - comm status byte at 7Eh, byte access
// - comm status shared by both channels
// - bit7 latches on invalid command
// - bit6 latches on invalid data
// - bit5 latches on packet check failure
// - bit3 latches on memory error
// - bit1 latches on other communication fault
// - comm bits 0,2,4 always read zero
// - write one clears comm flag
// - vendor status 80h paged, 00h A, 01h B
// - page FFh reads channel A
// - bit7 latches on power stage fault
// - bit6 latches if sense pin open at power-up
// - bit4 captures temperature level before soft-start
// - bit3 voltage code reset, page 0 only
// - bit0 after 7 consecutive imbalance detections
// - imbalanced phase identity readable separately
// - write one clears vendor flag
`timescale 1ns/1ns
`include "fault_status_defines.svh"
module fault_status_dev (
  input  wire logic                      I_CLOCK,
  input  wire logic                      I_RST,
  fault_status_if.dev                    LINK,
  input  wire logic                      i_invalid_command,
  input  wire logic                      i_invalid_data,
  input  wire logic                      i_packet_check_fail,
  input  wire logic                      i_memory_error,
  input  wire logic                      i_other_comm_fault,
  input  wire logic [1:0]                i_power_stage_fault,
  input  wire logic [1:0]                i_sense_pin_open,
  input  wire logic                      i_power_up,
  input  wire logic [3:0]                i_phase_cfg_a,
  input  wire logic [3:0]                i_phase_cfg_b,
  input  wire logic [11:0]               i_tsense_mv_a,
  input  wire logic [11:0]               i_tsense_mv_b,
  input  wire logic [1:0]                i_pre_soft_start,
  input  wire logic                      i_vcode_reset,
  input  wire logic [1:0]                i_imbalance_tick,
  input  wire logic [7:0]                i_imbalance_phases,
  output logic [3:0]                     o_phase_count_a,
  output logic [3:0]                     o_phase_count_b
);
  import fault_status_pkg::*;

  logic [7:0] comm_q;
  logic [7:0] vend_q [2];
  logic [2:0] share_cnt_q [2];
  logic [7:0] imb_q;
  logic       ch_b;
  logic       wr_comm;
  logic       wr_vend;
  logic [1:0] clamp;
  logic [1:0] tsense_hi;
  logic [7:0] comm_set;
  logic [7:0] vend_set [2];
  logic [7:0] vend_nxt [2];

  // page 01h picks B; 00h and FFh land on A
  assign ch_b    = (LINK.page == `PAGE_CH_B);
  assign wr_comm = (LINK.op == OP_WRITE) && (LINK.cmd == `CMD_COMM_STATUS);
  assign wr_vend = (LINK.op == OP_WRITE) && (LINK.cmd == `CMD_VENDOR_STATUS);

  // phase count clamp to the hardware maximum
  assign clamp[0] = i_phase_cfg_a > `PHASE_MAX_A;
  assign clamp[1] = i_phase_cfg_b > `PHASE_MAX_B;
  assign tsense_hi[0] = i_tsense_mv_a >= `TSENSE_THRESH_MV;
  assign tsense_hi[1] = i_tsense_mv_b >= `TSENSE_THRESH_MV;

  // clamp the operating count, registered so outputs are glitch free
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      o_phase_count_a <= 4'h0;
      o_phase_count_b <= 4'h0;
    end else begin
      o_phase_count_a <= clamp[0] ? `PHASE_MAX_A : i_phase_cfg_a;
      o_phase_count_b <= clamp[1] ? `PHASE_MAX_B : i_phase_cfg_b;
    end
  end

  // set terms; set beats a same-cycle clear so no event is lost
  always_comb begin
    comm_set = 8'h00;
    comm_set[`COMM_INV_CMD_BIT]  = i_invalid_command;
    comm_set[`COMM_INV_DATA_BIT] = i_invalid_data;
    comm_set[`COMM_PEC_BIT]      = i_packet_check_fail;
    comm_set[`COMM_MEM_BIT]      = i_memory_error;
    comm_set[`COMM_OTHER_BIT]    = i_other_comm_fault;
    for (int c = 0; c < 2; c++) begin
      vend_set[c] = 8'h00;
      vend_set[c][`VEND_PS_BIT]         = i_power_stage_fault[c];
      vend_set[c][`VEND_SENSE_OPEN_BIT] = i_power_up & i_sense_pin_open[c];
      vend_set[c][`VEND_PH_CLAMP_BIT]   = clamp[c];
      vend_set[c][`VEND_SHARE_BIT]      = i_imbalance_tick[c]
                                          && share_cnt_q[c] == `SHARE_FAULT_CYCLES - 3'd1;
    end
    vend_set[0][`VEND_VCODE_RST_BIT] = i_vcode_reset;
    // next vendor flags; temperature bit follows input before soft-start
    for (int c = 0; c < 2; c++) begin
      vend_nxt[c] = vend_q[c] & ~((wr_vend && ch_b == c[0]) ? LINK.wdata : 8'h00);
      vend_nxt[c] = vend_nxt[c] | vend_set[c];
      if (i_pre_soft_start[c])
        vend_nxt[c][`VEND_TSENSE_BIT] = tsense_hi[c];
      vend_nxt[c] = vend_nxt[c] & `VEND_IMPL_MASK;
    end
    vend_nxt[1][`VEND_VCODE_RST_BIT] = 1'b0;
  end

  // shared comm flags: write one clears, set wins, unused bits stay zero
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      comm_q <= `STATUS_RESET;
    end else begin
      comm_q <= ((comm_q & ~(wr_comm ? LINK.wdata : 8'h00)) | comm_set)
                & `COMM_IMPL_MASK;
    end
  end

  // per-channel vendor flags, one register per channel
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      vend_q[0] <= `STATUS_RESET;
      vend_q[1] <= `STATUS_RESET;
    end else begin
      vend_q[0] <= vend_nxt[0];
      vend_q[1] <= vend_nxt[1];
    end
  end

  // consecutive imbalance detections; a clean tick restarts the count
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      share_cnt_q[0] <= 3'd0;
      share_cnt_q[1] <= 3'd0;
      imb_q          <= 8'h00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (i_imbalance_tick[c] && share_cnt_q[c] != `SHARE_FAULT_CYCLES - 3'd1)
          share_cnt_q[c] <= share_cnt_q[c] + 3'd1;
        else if (!i_imbalance_tick[c])
          share_cnt_q[c] <= 3'd0;
      end
      imb_q <= i_imbalance_phases;
    end
  end

  // read answer one cycle after the request, held until the next read
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      LINK.rdata  <= 8'h00;
      LINK.rvalid <= 1'b0;
    end else begin
      LINK.rvalid <= (LINK.op == OP_READ);
      if (LINK.op == OP_READ) begin
        case (LINK.cmd)
          `CMD_COMM_STATUS:     LINK.rdata <= comm_q;
          `CMD_VENDOR_STATUS:   LINK.rdata <= ch_b ? vend_q[1] : vend_q[0];
          `CMD_PHASE_IMBALANCE: LINK.rdata <= imb_q;
          default:              LINK.rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule

// ==== design/fault_status_host.sv ====
// host end: turns register-port orders into byte reads and write-one-clears
`timescale 1ns/1ns
`include "fault_status_defines.svh"
module fault_status_host (
  input  wire logic                      I_CLOCK,
  input  wire logic                      I_RST,
  fault_status_if.host                   LINK,
  input  wire logic [7:0]                i_addr,
  input  wire logic [7:0]                i_wdata,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  input  wire logic [7:0]                i_page,
  output logic [7:0]                     o_rdata
);
  import fault_status_pkg::*;

  // strobes go straight onto the link so read data are back one cycle later;
  // the price is a combinational path from the register port into the decode
  always_comb begin
    LINK.op    = i_wr ? OP_WRITE : (i_rd ? OP_READ : OP_IDLE);
    LINK.cmd   = i_addr;
    LINK.page  = i_page;
    LINK.wdata = i_wdata; // write data of 1s clears flags
  end

  // device holds its answer register until the next read, so no copy here
  assign o_rdata = LINK.rdata;
endmodule

// ==== tb/fault_status_chk.sv ====
// link watcher for the status register pair
`timescale 1ns/1ns
module fault_status_chk (
  input wire logic                    I_CLOCK,
  input wire logic                    I_RST,
  input wire fault_status_pkg::op_t   op,
  input wire fault_status_pkg::byte_t cmd,
  input wire fault_status_pkg::byte_t page,
  input wire fault_status_pkg::byte_t wdata,
  input wire fault_status_pkg::byte_t rdata,
  input wire logic                    rvalid
);
  import fault_status_pkg::*;
  // one domain, so clock and reset are given once
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  // answers follow reads by exactly one edge
  chk_read_gets_answer: assert property (op == OP_READ |=> rvalid)
    else $error("read not answered");
  chk_no_stray_answer: assert property (rvalid |-> $past(op) == OP_READ)
    else $error("answer without read");
  chk_write_is_silent: assert property (op == OP_WRITE |=> !rvalid)
    else $error("answer after write");
  // read data only moves with an answer
  chk_rdata_holds: assert property (!rvalid |-> $stable(rdata))
    else $error("read data moved");
  chk_comm_zero_bits: assert property (op == OP_READ && cmd == 8'h7E
    |=> (rdata & 8'h15) == 8'h00) else $error("comm reserved bit set");
  chk_vendor_zero_bits: assert property (op == OP_READ && cmd == 8'h80
    |=> (rdata & 8'h06) == 8'h00) else $error("vendor reserved bit set");
  chk_vcode_page_a: assert property (op == OP_READ && cmd == 8'h80 && page == 8'h01
    |=> !rdata[3]) else $error("voltage code flag on channel b");
  chk_unknown_cmd_zero: assert property (op == OP_READ
    && !(cmd inside {8'h7E, 8'h80, 8'hD3}) |=> rdata == 8'h00) else $error("unknown read");
endmodule

// ==== tb/pmbus_comm_and_vendor_fault_status_tb_top.sv ====
// bench joining host end and device end over the status link
`timescale 1ns/1ns
module pmbus_comm_and_vendor_fault_status_tb_top;
  logic        clk, rst, wr, rd, pwr_up, vrst;
  logic [7:0]  addr, wdata, page, rdata, phases;
  logic [4:0]  cf;
  logic [1:0]  ps, opn, pss, tick;
  logic [3:0]  cfg_a, cfg_b, cnt_a, cnt_b;
  logic [11:0] ts_a, ts_b;
  int          num_errors, checked;
  fault_status_if link ();
  fault_status_host u_fault_status_host (.I_CLOCK(clk), .I_RST(rst), .LINK(link), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_page(page), .o_rdata(rdata));
  fault_status_dev u_fault_status_dev (.I_CLOCK(clk), .I_RST(rst), .LINK(link),
    .i_invalid_command(cf[4]), .i_invalid_data(cf[3]), .i_packet_check_fail(cf[2]),
    .i_memory_error(cf[1]), .i_other_comm_fault(cf[0]), .i_power_stage_fault(ps),
    .i_sense_pin_open(opn), .i_power_up(pwr_up), .i_phase_cfg_a(cfg_a), .i_phase_cfg_b(cfg_b),
    .i_tsense_mv_a(ts_a), .i_tsense_mv_b(ts_b), .i_pre_soft_start(pss), .i_vcode_reset(vrst),
    .i_imbalance_tick(tick), .i_imbalance_phases(phases), .o_phase_count_a(cnt_a),
    .o_phase_count_b(cnt_b));
  fault_status_chk u_fault_status_chk (.I_CLOCK(clk), .I_RST(rst), .op(link.op), .cmd(link.cmd),
    .page(link.page), .wdata(link.wdata), .rdata(link.rdata), .rvalid(link.rvalid));
  // 50 MHz clock
  initial clk = 1'b0;
  always #10 clk = ~clk;
  task automatic cmp(input string nm, input logic [7:0] exp, input logic [7:0] seen);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one-cycle write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] pg, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    page <= pg;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand in the cycle after the strobe is taken
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] pg, input logic [7:0] exp,
                        input string nm);
    @(posedge clk);
    addr <= a;
    page <= pg;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    cmp(nm, exp, rdata);
  endtask
  // phase counts sit exactly at their maxima here
  task automatic t_reset;
    rd_reg(8'h7E, 8'h00, 8'h00, "comm reset");
    rd_reg(8'h80, 8'h00, 8'h00, "vendor a reset");
    rd_reg(8'h80, 8'h01, 8'h00, "vendor b reset");
    rd_reg(8'h7F, 8'h00, 8'h00, "unknown command");
  endtask
  task automatic t_comm;
    @(posedge clk);
    cf <= 5'h1F;
    @(posedge clk);
    cf <= 5'h00;
    rd_reg(8'h7E, 8'h00, 8'hEA, "comm all");
    rd_reg(8'h7E, 8'h01, 8'hEA, "comm page b");
    wr_reg(8'h7E, 8'h01, 8'h20);
    rd_reg(8'h7E, 8'hFF, 8'hCA, "comm one cleared");
    wr_reg(8'h7E, 8'h00, 8'hFF);
    rd_reg(8'h7E, 8'h00, 8'h00, "comm cleared");
    // fault still present while it is cleared: the set must win
    @(posedge clk);
    cf <= 5'h01;
    wr_reg(8'h7E, 8'h00, 8'hFF);
    cf <= 5'h00;
    rd_reg(8'h7E, 8'h00, 8'h02, "comm set wins");
  endtask
  // channel a gets 7 imbalance ticks, b only 6; temperature at and below threshold
  task automatic t_vendor;
    @(posedge clk);
    {cfg_a, cfg_b, ps, opn, pwr_up, vrst, pss, tick} <= {4'h7, 4'h3, 2'b11, 2'b01, 4'hF, 2'b11};
    ts_a <= 12'd150;
    ts_b <= 12'd149;
    @(posedge clk);
    {ps, opn, pwr_up, vrst, pss} <= {2'b00, 2'b10, 4'h0};
    repeat (5) @(posedge clk);
    tick <= 2'b01;
    @(posedge clk);
    tick <= 2'b00;
    opn <= 2'b00;
    rd_reg(8'h80, 8'h00, 8'hF9, "vendor a");
    rd_reg(8'h80, 8'hFF, 8'hF9, "vendor all page");
    rd_reg(8'h80, 8'h01, 8'hA0, "vendor b");
    rd_reg(8'hD3, 8'h00, 8'h5A, "imbalanced phases");
    cmp("count a", 8'h06, {4'h0, cnt_a});
    cmp("count b", 8'h02, {4'h0, cnt_b});
    wr_reg(8'h80, 8'h00, 8'hEF);
    rd_reg(8'h80, 8'h00, 8'h30, "vendor a cleared");
    wr_reg(8'h80, 8'h01, 8'hFF);
    rd_reg(8'h80, 8'h01, 8'h20, "vendor b cleared");
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    {wr, rd, pwr_up, vrst, addr, wdata, page, cf, ps, opn, pss, tick, ts_a, ts_b} = '0;
    {cfg_a, cfg_b, phases} = {4'h6, 4'h2, 8'h5A};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_comm;
    t_vendor;
    close_out;
  end
  // the tests need about 60 cycles; a thousand means a hang
  initial begin
    #20000;
    num_errors++;
    close_out;
  end
endmodule
